// ### design/controller_end.sv
// Controller end: AXI4-Lite command registers driving the process image
`include "regcomm_consts.svh"
module controller_end
    import regcomm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Process image
    process_image_if.controller img,
    // AXI4-Lite write address and data
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = res;
    endfunction : merge

    function automatic logic mapped(input logic [3:0] ofs);
        mapped = (ofs == `OFS_CMD) || (ofs == `OFS_WDATA)
            || (ofs == `OFS_STAT) || (ofs == `OFS_RDATA);
    endfunction : mapped

    ctl_state_type state_reg;
    ctl_state_type state_next;
    logic tick;
    logic busy;
    logic [7:0] expect_stat;
    logic [31:0] cmd_word;
    logic [31:0] wdata_word;

    assign tick = (state_reg.tick_cnt == `CYCLE_DIV);
    assign busy = (state_reg.phase != C_IDLE);
    assign expect_stat = state_reg.ctrl_out[`DIR_BIT]
        ? (state_reg.ctrl_out & `DIR_MASK) : state_reg.ctrl_out;
    assign cmd_word = merge({24'h000000, state_reg.cmd}, state_reg.w_dat,
        state_reg.w_strb);
    assign wdata_word = merge({16'h0000, state_reg.wdata}, state_reg.w_dat,
        state_reg.w_strb);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        state_next = state_reg;
        state_next.tick_cnt = tick ? `CLR_BYTE : state_reg.tick_cnt + `CNT_ONE;
        if (awvalid && awready)
        begin
            state_next.aw_got = 1'b1;
            state_next.aw_ofs = awaddr[3:0];
        end
        if (wvalid && wready)
        begin
            state_next.w_got = 1'b1;
            state_next.w_dat = wdata;
            state_next.w_strb = wstrb;
        end
        if (state_reg.aw_got && state_reg.w_got)
        begin
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = mapped(state_reg.aw_ofs) ? `RESP_OKAY : `RESP_SLVERR;
            if (state_reg.aw_ofs == `OFS_WDATA)
            begin
                state_next.wdata = wdata_word[15:0];
            end
            else if (state_reg.aw_ofs == `OFS_CMD && !busy
                && cmd_word[`MODE_BIT])
            begin
                state_next.cmd = cmd_word[7:0];
                state_next.done = 1'b0;
                state_next.phase = C_SEND;
                state_next.ctrl_out = cmd_word[7:0];
                state_next.hi_out = state_reg.wdata[15:8];
                state_next.lo_out = state_reg.wdata[7:0];
            end
        end
        if (bvalid && bready)
        begin
            state_next.bvalid = 1'b0;
        end
        if (arvalid && arready)
        begin
            state_next.rvalid = 1'b1;
            state_next.rresp = mapped(araddr[3:0]) ? `RESP_OKAY : `RESP_SLVERR;
            case (araddr[3:0])
                `OFS_CMD: state_next.rdata = {24'h000000, state_reg.cmd};
                `OFS_WDATA: state_next.rdata = {16'h0000, state_reg.wdata};
                `OFS_STAT: state_next.rdata = {22'h000000, busy,
                    state_reg.done, state_reg.stat};
                `OFS_RDATA: state_next.rdata = {16'h0000, state_reg.rword};
                default: state_next.rdata = 32'h00000000;
            endcase
        end
        if (rvalid && rready)
        begin
            state_next.rvalid = 1'b0;
        end
        case (state_reg.phase)
            C_IDLE:
            begin
            end
            C_SEND:
            begin
                if (tick && img.stat_byte == expect_stat)
                begin
                    state_next.stat = img.stat_byte;
                    if (!state_reg.ctrl_out[`DIR_BIT])
                    begin
                        state_next.rword = {img.in_hi, img.in_lo};
                    end
                    // Input word after a write is left unread
                    state_next.done = 1'b1;
                    // Zero control byte makes the next command a new value
                    state_next.ctrl_out = `CLR_BYTE;
                    state_next.phase = C_GAP;
                end
            end
            C_GAP:
            begin
                if (tick)
                begin
                    state_next.phase = C_IDLE;
                end
            end
            default:
            begin
                state_next.phase = C_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= '0;
            state_reg.phase <= C_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready = !state_reg.aw_got && !state_reg.bvalid;
    assign wready = !state_reg.w_got && !state_reg.bvalid;
    assign bvalid = state_reg.bvalid;
    assign bresp = state_reg.bresp;
    assign arready = !state_reg.rvalid;
    assign rvalid = state_reg.rvalid;
    assign rdata = state_reg.rdata;
    assign rresp = state_reg.rresp;
    assign img.update_tick = tick;
    assign img.ctrl_byte = state_reg.ctrl_out;
    assign img.data_hi = state_reg.hi_out;
    assign img.data_lo = state_reg.lo_out;

endmodule : controller_end

// ### design/regcomm_consts.svh
// Constants of the register path through the cyclic process image
`ifndef REGCOMM_CONSTS_SVH
`define REGCOMM_CONSTS_SVH
`define MODE_BIT 7
`define DIR_BIT 6
`define NUM_MSB 5
`define DIR_MASK 8'hBF
`define KEY_REG_NUM 6'h1F
`define FEATURE_REG_NUM 6'h20
`define UNLOCK_KEY 16'h1235
`define CLR_BYTE 8'h00
`define CLR_WORD 16'h0000
`define CYCLE_DIV 8'h07
`define CNT_ONE 8'h01
`define OFS_CMD 4'h0
`define OFS_WDATA 4'h4
`define OFS_STAT 4'h8
`define OFS_RDATA 4'hC
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### design/regcomm_pkg.sv
// Types shared by both ends of the register path
package regcomm_pkg;

typedef enum logic {DEV_BOOT, DEV_RUN} dev_phase_type;

typedef enum logic [1:0] {C_IDLE, C_SEND, C_GAP} ctl_phase_type;

typedef struct packed {
    dev_phase_type phase;
    logic [7:0] last_ctrl;
    logic [7:0] stat;
    logic [15:0] in_word;
    logic [15:0] feat;
} dev_state_type;

typedef struct packed {
    ctl_phase_type phase;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic [7:0] stat;
    logic [15:0] rword;
    logic done;
    logic [7:0] tick_cnt;
    logic [7:0] ctrl_out;
    logic [7:0] hi_out;
    logic [7:0] lo_out;
    logic aw_got;
    logic [3:0] aw_ofs;
    logic w_got;
    logic [31:0] w_dat;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
} ctl_state_type;

endpackage : regcomm_pkg

// ### design/process_image_if.sv
// Cyclic process image between controller and terminal
interface process_image_if;
    // Update strobe of the cyclic exchange
    logic update_tick;
    // Output image: control byte, then word high and low byte
    logic [7:0] ctrl_byte;
    logic [7:0] data_hi;
    logic [7:0] data_lo;
    // Input image: status byte, then word high and low byte
    logic [7:0] stat_byte;
    logic [7:0] in_hi;
    logic [7:0] in_lo;

    modport device (
        input update_tick,
        input ctrl_byte,
        input data_hi,
        input data_lo,
        output stat_byte,
        output in_hi,
        output in_lo
    );

    modport controller (
        output update_tick,
        output ctrl_byte,
        output data_hi,
        output data_lo,
        input stat_byte,
        input in_hi,
        input in_lo
    );
endinterface : process_image_if

// ### design/user_reg_bank.sv
// Storage of the 64 user registers of the terminal
`include "regcomm_consts.svh"
module user_reg_bank
    import regcomm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write port
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire logic [15:0] wdata,
    // Read port
    input wire logic [5:0] raddr,
    output logic [15:0] rdata,
    // Fixed taps
    output logic [15:0] key_word,
    output logic [15:0] feature_word
);

    // Contents survive a restart, except the unlock key
    logic [15:0] mem_reg [64] = '{default: `CLR_WORD};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem_reg[`KEY_REG_NUM] <= `CLR_WORD;
        end
        else if (we)
        begin
            mem_reg[waddr] <= wdata;
        end
    end

    assign rdata = mem_reg[raddr];
    assign key_word = mem_reg[`KEY_REG_NUM];
    assign feature_word = mem_reg[`FEATURE_REG_NUM];

endmodule : user_reg_bank

// ### design/terminal_end.sv
// Terminal end: register communication through the process image
//
// Functional notes
// - Only key register writable while locked
// - Key 0x1235 in register 31 unlocks writes
// - Any other key value relocks
// - Written values other than the key act only after restart
// - Control bit 7 selects register communication
// - Control bit 6: one write, zero read
// - Bits 5..0 carry register number
// - Write receipt is control with bit 6 cleared
// - Read receipt echoes control byte
// - Read returns addressed register content
// - Master ignores input word after write
// - Output word ignored during read
// - Word travels high byte then low byte
// - Master reads key back before writing; controller_end sends each command without reading the key back
// - Key register cleared at every restart
`include "regcomm_consts.svh"
module terminal_end
    import regcomm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Process image
    process_image_if.device img,
    // User side
    output logic [15:0] feature_active,
    output logic config_valid,
    output logic unlocked
);

    ////////////////////////////////////////////////////////////////////////
    // Control byte decoding

    function automatic logic is_reg_mode(input logic [7:0] ctrl);
        is_reg_mode = ctrl[`MODE_BIT];
    endfunction : is_reg_mode

    function automatic logic is_write(input logic [7:0] ctrl);
        is_write = ctrl[`DIR_BIT];
    endfunction : is_write

    function automatic logic [5:0] reg_num(input logic [7:0] ctrl);
        reg_num = ctrl[`NUM_MSB:0];
    endfunction : reg_num

    function automatic logic is_key_reg(input logic [5:0] num);
        is_key_reg = (num == `KEY_REG_NUM);
    endfunction : is_key_reg

    // Key register stays writable while the bank is locked
    function automatic logic write_allowed(input logic is_open, input logic [5:0] num);
        write_allowed = is_open || is_key_reg(num);
    endfunction : write_allowed

    ////////////////////////////////////////////////////////////////////////
    // Receipt and word helpers

    // Write receipt drops the direction bit, read receipt echoes
    function automatic logic [7:0] receipt_of(input logic [7:0] ctrl);
        if (is_write(ctrl))
        begin
            receipt_of = ctrl & `DIR_MASK;
        end
        else
        begin
            receipt_of = ctrl;
        end
    endfunction : receipt_of

    function automatic logic [15:0] word_of(input logic [7:0] hi, input logic [7:0] lo);
        word_of = {hi, lo};
    endfunction : word_of

    function automatic logic [7:0] hi_byte(input logic [15:0] word);
        hi_byte = word[15:8];
    endfunction : hi_byte

    function automatic logic [7:0] lo_byte(input logic [15:0] word);
        lo_byte = word[7:0];
    endfunction : lo_byte

    ////////////////////////////////////////////////////////////////////////
    // State and bank signals

    dev_state_type state_reg;
    dev_state_type state_next;

    logic bank_we;
    logic [5:0] bank_waddr;
    logic [15:0] bank_wdata;
    logic [5:0] bank_raddr;
    logic [15:0] bank_rdata;
    logic [15:0] key_word;
    logic [15:0] feature_word;
    logic new_ctrl;
    logic [15:0] out_word;

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    user_reg_bank bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(bank_we),
        .waddr(bank_waddr),
        .wdata(bank_wdata),
        .raddr(bank_raddr),
        .rdata(bank_rdata),
        .key_word(key_word),
        .feature_word(feature_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Image decoding

    // Data word is assembled from the high byte and the low byte
    assign out_word = word_of(img.data_hi, img.data_lo);

    // Only a changed control byte starts an access
    assign new_ctrl = img.update_tick
        && (img.ctrl_byte != state_reg.last_ctrl);

    assign unlocked = (key_word == `UNLOCK_KEY);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        state_next = state_reg;
        bank_we = 1'b0;
        bank_waddr = reg_num(img.ctrl_byte);
        bank_wdata = out_word;
        bank_raddr = reg_num(img.ctrl_byte);
        case (state_reg.phase)
            DEV_BOOT:
            begin
                // Operating copy is taken once, right after restart
                state_next.feat = feature_word;
                state_next.phase = DEV_RUN;
            end
            DEV_RUN:
            begin
                if (new_ctrl)
                begin
                    state_next.last_ctrl = img.ctrl_byte;
                    if (is_reg_mode(img.ctrl_byte))
                    begin
                        if (is_write(img.ctrl_byte))
                        begin
                            // Key register is writable even when locked
                            bank_we = write_allowed(unlocked,
                                reg_num(img.ctrl_byte));
                            state_next.stat = receipt_of(img.ctrl_byte);
                            // Input word has no meaning after a write
                            state_next.in_word = `CLR_WORD;
                        end
                        else
                        begin
                            // Output word is not looked at on a read
                            state_next.stat = receipt_of(img.ctrl_byte);
                            state_next.in_word = bank_rdata;
                        end
                    end
                    else
                    begin
                        // Leaving register mode blanks the answer
                        state_next.stat = `CLR_BYTE;
                        state_next.in_word = `CLR_WORD;
                    end
                end
            end
            default:
            begin
                state_next.phase = DEV_BOOT;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg.phase <= DEV_BOOT;
            state_reg.last_ctrl <= `CLR_BYTE;
            state_reg.stat <= `CLR_BYTE;
            state_reg.in_word <= `CLR_WORD;
            state_reg.feat <= `CLR_WORD;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign img.stat_byte = state_reg.stat;
    assign img.in_hi = hi_byte(state_reg.in_word);
    assign img.in_lo = lo_byte(state_reg.in_word);

    // Written values other than the key do not reach the user side before a restart
    assign feature_active = state_reg.feat;
    assign config_valid = (state_reg.phase == DEV_RUN);

endmodule : terminal_end

// ### verif/regcomm_asserts.sv
// Checker of the process image exchange between both ends
module regcomm_asserts
    import regcomm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Process image
    input wire logic update_tick,
    input wire logic [7:0] ctrl_byte,
    input wire logic [7:0] data_hi,
    input wire logic [7:0] data_lo,
    input wire logic [7:0] stat_byte,
    input wire logic [7:0] in_hi,
    input wire logic [7:0] in_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_reg;
    logic [15:0] key_reg;
    // Feature word survives reset, as in the terminal
    logic [15:0] feat_reg = 16'h0000;
    logic take;
    assign take = update_tick && (ctrl_byte != last_reg);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            last_reg <= 8'h00;
            key_reg <= 16'h0000;
        end
        else if (take)
        begin
            last_reg <= ctrl_byte;
            if (ctrl_byte == 8'hDF)
                key_reg <= {data_hi, data_lo};
            if (ctrl_byte == 8'hE0 && key_reg == 16'h1235)
                feat_reg <= {data_hi, data_lo};
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////
    AST_TICK_PERIOD: assert property (update_tick |=> !update_tick [*7] ##1 update_tick)
        else $error("update tick period wrong");
    AST_WRITE_RECEIPT: assert property (take && ctrl_byte[7] && ctrl_byte[6]
        |=> stat_byte == ($past(ctrl_byte) & 8'hBF)) else $error("write receipt wrong");
    AST_READ_RECEIPT: assert property (take && ctrl_byte[7:6] == 2'b10
        |=> stat_byte == $past(ctrl_byte)) else $error("read receipt wrong");
    AST_OFF_MODE: assert property (take && !ctrl_byte[7]
        |=> stat_byte == 8'h00 && {in_hi, in_lo} == 16'h0000) else $error("idle image wrong");
    AST_KEY_READ: assert property (take && ctrl_byte == 8'h9F
        |=> {in_hi, in_lo} == key_reg) else $error("key readback wrong");
    AST_FEAT_READ: assert property (take && ctrl_byte == 8'hA0
        |=> {in_hi, in_lo} == feat_reg) else $error("feature readback wrong");
    AST_HOLD: assert property (!take |=> $stable(stat_byte) && $stable({in_hi, in_lo}))
        else $error("answer changed without access");
    AST_STAT_BIT6: assert property (stat_byte[6] == 1'b0)
        else $error("receipt direction bit set");
    AST_ACK_BOUND: assert property ($rose(ctrl_byte[7]) |-> ##[1:24] stat_byte[7])
        else $error("no receipt in time");
endmodule : regcomm_asserts

// ### verif/testbench.sv
// Testbench driving both ends over AXI4-Lite and the process image
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [31:0] araddr = 32'h0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [15:0] feature_active;
    logic config_valid;
    logic unlocked;
    logic [31:0] q;
    logic [1:0] r;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    always #12.5 aclk = ~aclk;
    process_image_if pimg();
    controller_end controller_end_i (.aclk(aclk), .aresetn(aresetn), .img(pimg),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    terminal_end terminal_end_i (.aclk(aclk), .aresetn(aresetn), .img(pimg),
        .feature_active(feature_active), .config_valid(config_valid), .unlocked(unlocked));
    regcomm_asserts regcomm_asserts_i (.aclk(aclk), .aresetn(aresetn),
        .update_tick(pimg.update_tick), .ctrl_byte(pimg.ctrl_byte), .data_hi(pimg.data_hi),
        .data_lo(pimg.data_lo), .stat_byte(pimg.stat_byte), .in_hi(pimg.in_hi),
        .in_lo(pimg.in_lo));
    ////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check
    // One AXI4-Lite transfer; the bench timeout cuts a hang
    task axi(input logic wr, input logic [31:0] a, input logic [31:0] d);
        logic fin;
        fin = 1'b0;
        q = 32'h0;
        @(posedge aclk);
        if (wr)
        begin
            awaddr <= a;
            awvalid <= 1'b1;
            wdata <= d;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end
        else
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        while (!fin)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (bready && bvalid)
            begin
                bready <= 1'b0;
                r = bresp;
                fin = 1'b1;
            end
            if (rready && rvalid)
            begin
                rready <= 1'b0;
                r = rresp;
                q = rdata;
                fin = 1'b1;
            end
        end
    endtask : axi
    // Issue one register access and wait for its receipt
    task acc(input logic [7:0] c, input logic [15:0] w, input logic [7:0] es);
        int n;
        axi(1'b1, 32'h4, {16'h0000, w});
        axi(1'b1, 32'h0, {24'h000000, c});
        n = 0;
        q = 32'h0000_0200;
        while ((q[9] || !q[8]) && n < 100)
        begin
            axi(1'b0, 32'h8, 32'h0);
            n++;
        end
        check("done", 32'h1, {30'h0, q[9:8]});
        check("receipt", {24'h000000, es}, {24'h000000, q[7:0]});
    endtask : acc
    task rdw(input logic [15:0] exp);
        axi(1'b0, 32'hC, 32'h0);
        check("word", {16'h0000, exp}, q);
    endtask : rdw
    task rst;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask : rst
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst;
        check("unlocked", 32'h0, {31'h0, unlocked});
        acc(8'hE0, 16'h0002, 8'hA0);
        acc(8'hA0, 16'hBEEF, 8'hA0);
        rdw(16'h0000);
        check("rresp", 32'h0, {30'h0, r});
        acc(8'hDF, 16'h1235, 8'h9F);
        check("unlocked", 32'h1, {31'h0, unlocked});
        acc(8'h9F, 16'h5AA5, 8'h9F);
        rdw(16'h1235);
        axi(1'b0, 32'h4, 32'h0);
        check("wdata", 32'h5AA5, q);
        axi(1'b0, 32'h0, 32'h0);
        check("cmd", 32'h9F, q);
        acc(8'hE0, 16'h0002, 8'hA0);
        acc(8'hA0, 16'h0000, 8'hA0);
        rdw(16'h0002);
        check("feature", 32'h0, {16'h0, feature_active});
        acc(8'hDF, 16'h0000, 8'h9F);
        check("unlocked", 32'h0, {31'h0, unlocked});
        acc(8'hE0, 16'h0055, 8'hA0);
        acc(8'hA0, 16'h0000, 8'hA0);
        rdw(16'h0002);
        rst;
        check("valid", 32'h1, {31'h0, config_valid});
        check("feature", 32'h2, {16'h0, feature_active});
        acc(8'h9F, 16'h0000, 8'h9F);
        rdw(16'h0000);
        axi(1'b1, 32'h4, 32'h0000_1234);
        check("bresp", 32'h0, {30'h0, r});
        axi(1'b0, 32'h4, 32'h0);
        check("wdata", 32'h1234, q);
        axi(1'b0, 32'h2, 32'h0);
        check("rresp", 32'h2, {30'h0, r});
        axi(1'b1, 32'h2, 32'h0);
        check("bresp", 32'h2, {30'h0, r});
        tally_and_finish;
    end
endmodule : testbench
